// ==== pau_pkg.sv ====
// Types shared by the alarm unit modules.
package pau_pkg;
   typedef enum logic [2:0] {
      PAU_FN_OFF,
      PAU_FN_SENSOR_BREAK,
      PAU_FN_PROFILE_EVENT,
      PAU_FN_MIN_ABS,
      PAU_FN_MAX_ABS,
      PAU_FN_DEV_BAND,
      PAU_FN_MIN_DEV,
      PAU_FN_MAX_DEV
   } pau_func_t;
   typedef enum logic [2:0] {
      PAU_TS_IDLE,
      PAU_TS_ON,
      PAU_TS_OFF,
      PAU_TS_HOLD,
      PAU_TS_DONE
   } pau_tstate_t;
endpackage

// ==== pau_proc_model.sv ====
// Behavioural model of the process input, setpoint source and run switch.
module pau_proc_model (
   input  wire logic          clk_sys_in,
   output logic signed [15:0] pv_out,
   output logic signed [15:0] main_sp_out,
   output logic               sensor_err_out,
   output logic [3:0]         profile_event_out,
   output logic               run_out
);
   // Everything starts quiet with the switch in run and the setpoint at 1000.
   initial begin
      pv_out = 16'sh0100;
      main_sp_out = 16'sh03E8;
      sensor_err_out = 1'b0;
      profile_event_out = 4'h0;
      run_out = 1'b1;
   end

   // Steps the process just after the next rising edge.
   task automatic drive(input logic signed [15:0] pv, input logic err,
                        input logic [3:0] ev, input logic run);
      @(posedge clk_sys_in);
      pv_out <= pv;
      sensor_err_out <= err;
      profile_event_out <= ev;
      run_out <= run;
   endtask
endmodule

// ==== pau_regs.svh ====
// Register offsets, reset values and timing counts of the alarm unit.
`ifndef PAU_REGS_SVH
`define PAU_REGS_SVH
`define PAU_A_CTRL      6'h00
`define PAU_A_STATUS    6'h01
`define PAU_A_IRQ_STAT  6'h02
`define PAU_A_IRQ_MASK  6'h03
`define PAU_A_BLOCK     6'h04
`define PAU_A_FN_BASE   6'h08
`define PAU_A_ASP_BASE  6'h0C
`define PAU_A_TMR_BASE  6'h10
`define PAU_CTRL_EN_BIT 0
`define PAU_RST_WORD    16'h0000
`define PAU_RST_NIB     4'h0
`define PAU_TIMER_MAX_S 13'h1964
`define PAU_TICK_TIME_NS  1000000000
`define PAU_CLK_PERIOD_NS 100
`define PAU_TICK_CYCLES (`PAU_TICK_TIME_NS / `PAU_CLK_PERIOD_NS)
`endif

// ==== pau_tick.sv ====
// One-second tick generator driven by the system clock.
module pau_tick #(
   parameter int TICK_CYCLES = 10
) (
   input  wire logic clk_sys_in,
   input  wire logic rst_n_in,
   output logic      tick_out
);
   localparam int CW = $clog2(TICK_CYCLES + 1);
   localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES - 1);
   logic [CW-1:0] cnt_q;

   // Counts system cycles and pulses once per second.
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         cnt_q    <= '0;
         tick_out <= 1'b0;
      end else begin
         cnt_q    <= (cnt_q == LAST) ? '0 : cnt_q + CW'(1);
         tick_out <= (cnt_q == LAST);
      end
   end

   a_tick_single: assert property (@(posedge clk_sys_in)
      disable iff (!rst_n_in) tick_out |=> !tick_out)
      else $error("Tick lasted more than one cycle.");
endmodule

// ==== pau_timer.sv ====
// Pulse, delay and intermittent shaping of one alarm output.
module pau_timer #(
   parameter int TW = 13
) (
   input  wire logic          clk_sys_in,
   input  wire logic          rst_n_in,
   input  wire logic          tick_in,
   input  wire logic          cond_in,
   input  wire logic [TW-1:0] t1_in,
   input  wire logic [TW-1:0] t2_in,
   output logic               out_out
);
   pau_pkg::pau_tstate_t state_q, state_d;
   logic [TW-1:0] cnt_q, cnt_d;
   wire [TW-1:0] cnt_inc = cnt_q + TW'(1);
   wire t1_set = (t1_in != '0);
   wire t2_set = (t2_in != '0);
   wire hit1   = tick_in && (cnt_inc == t1_in);
   wire hit2   = tick_in && (cnt_inc == t2_in);

   // Next state: phases advance on ticks, a dropped condition clears all.
   always_comb begin
      state_d = state_q;
      cnt_d   = tick_in ? cnt_inc : cnt_q;
      case (state_q)
         pau_pkg::PAU_TS_IDLE: begin
            cnt_d = '0;
            if (t1_set) begin
               state_d = pau_pkg::PAU_TS_ON;
            end else if (t2_set) begin
               state_d = pau_pkg::PAU_TS_OFF;
            end
         end
         pau_pkg::PAU_TS_ON: begin
            if (hit1) begin
               cnt_d   = '0;
               state_d = t2_set ? pau_pkg::PAU_TS_OFF
                                : pau_pkg::PAU_TS_DONE;
            end
         end
         pau_pkg::PAU_TS_OFF: begin
            if (hit2) begin
               cnt_d   = '0;
               state_d = t1_set ? pau_pkg::PAU_TS_ON
                                : pau_pkg::PAU_TS_HOLD;
            end
         end
         default: cnt_d = '0;
      endcase
      if (!cond_in) begin
         state_d = pau_pkg::PAU_TS_IDLE;
         cnt_d   = '0;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         state_q <= pau_pkg::PAU_TS_IDLE;
         cnt_q   <= '0;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
      end
   end

   // Output is on in the on phase, the held delay, or plain follow mode,
   // and only while the condition holds, so a dropped alarm ends it at once.
   assign out_out = cond_in && ((state_q == pau_pkg::PAU_TS_ON)
                 || (state_q == pau_pkg::PAU_TS_HOLD)
                 || (!t1_set && !t2_set));

   sequence s_pulse_end;
      state_q == pau_pkg::PAU_TS_ON && hit1 && !t2_set && cond_in;
   endsequence
   sequence s_delay_end;
      state_q == pau_pkg::PAU_TS_OFF && hit2 && !t1_set && cond_in;
   endsequence

   a_direct_follow: assert property (@(posedge clk_sys_in)
      disable iff (!rst_n_in) (!t1_set && !t2_set) |-> out_out == cond_in)
      else $error("Untimed output does not follow the condition.");
   a_pulse_once: assert property (@(posedge clk_sys_in)
      disable iff (!rst_n_in)
      s_pulse_end ##1 cond_in && t1_in == $past(t1_in)
      && !t2_set |-> !out_out)
      else $error("Single pulse did not end after its time.");
   a_delay_hold: assert property (@(posedge clk_sys_in)
      disable iff (!rst_n_in)
      s_delay_end ##1 cond_in && !t1_set |-> out_out)
      else $error("Delayed output did not assert.");
   a_timer_clear: assert property (@(posedge clk_sys_in)
      disable iff (!rst_n_in)
      !cond_in |=> state_q == pau_pkg::PAU_TS_IDLE && cnt_q == '0)
      else $error("Timer state not cleared when alarm ended.");
endmodule

// ==== pau_top.sv ====
// Four-channel process alarm unit with register port and timers.
// Function
// - Four independent alarm channels with own settings.
// - Disabled channel never alarms or lights.
// - Sensor fault alarms on open, short, range.
// - Event function alarms on current segment event.
// - Minimum alarm when value below alarm setpoint.
// - Maximum alarm when value above alarm setpoint.
// - Band alarm outside, or inside when negative.
// - Max deviation: value above setpoint plus offset.
// - Channels one, two: two timers, zero follows.
// - First timer only: one pulse at onset.
// - Second only delays; both give intermittent.
// - Lamps show recognized condition, not timed output.
// - Initial blocking hides condition true at start.
// - Blocked alarm recovers after false then true.
// - Sensor fault function ignores initial blocking.
// - Stop input holds every alarm output off.
//
// Implementation choices: the register offsets and the strobed register port.
`include "pau_regs.svh"
module pau_top #(
   parameter int TICK_CYCLES = `PAU_TICK_CYCLES,
   parameter int DW          = 16,
   parameter int TW          = 13
) (
   input  wire logic                 clk_sys_in,
   input  wire logic                 rst_n_in,
   input  wire logic [5:0]           addr_in,
   input  wire logic [DW-1:0]        wr_data_in,
   input  wire logic                 wr_in,
   input  wire logic                 rd_in,
   output logic      [DW-1:0]        rd_data_out,
   input  wire logic signed [DW-1:0] pv_in,
   input  wire logic signed [DW-1:0] main_sp_in,
   input  wire logic                 sensor_err_in,
   input  wire logic [3:0]           profile_event_in,
   input  wire logic                 run_in,
   output logic      [3:0]           alarm_out,
   output logic      [3:0]           lamp_out,
   output logic                      irq_out
);
   localparam int NCH = 4;
   localparam int NTM = 2;

   // Evaluates one channel's raw alarm condition.
   function automatic logic eval_cond(
      input pau_pkg::pau_func_t fn,
      input logic signed [DW-1:0] pv,
      input logic signed [DW-1:0] sp,
      input logic signed [DW-1:0] asp,
      input logic err,
      input logic evt);
      logic signed [DW+1:0] hi;
      logic signed [DW+1:0] lo;
      logic signed [DW+1:0] v;
      logic c;
      hi = (DW+2)'(sp) + (DW+2)'(asp);
      lo = (DW+2)'(sp) - (DW+2)'(asp);
      v  = (DW+2)'(pv);
      case (fn)
         pau_pkg::PAU_FN_SENSOR_BREAK:  c = err;
         pau_pkg::PAU_FN_PROFILE_EVENT: c = evt;
         pau_pkg::PAU_FN_MIN_ABS:       c = pv < asp;
         pau_pkg::PAU_FN_MAX_ABS:       c = pv > asp;
         pau_pkg::PAU_FN_DEV_BAND: begin
            if (asp >= 0) begin
               c = (v < lo) || (v > hi);
            end else begin
               c = (v >= hi) && (v <= lo);
            end
         end
         pau_pkg::PAU_FN_MIN_DEV:       c = v < hi;
         pau_pkg::PAU_FN_MAX_DEV:       c = v > hi;
         default:                       c = 1'b0;
      endcase
      return c;
   endfunction

   // Limits a written timer value to the longest allowed time.
   function automatic logic [TW-1:0] clamp_time(
      input logic [DW-1:0] w);
      logic [TW-1:0] r;
      r = (w > DW'(`PAU_TIMER_MAX_S)) ? `PAU_TIMER_MAX_S : w[TW-1:0];
      return r;
   endfunction

   logic                     en_q;
   logic                     en_prev_q;
   logic [3:0]               blk_en_q;
   logic [3:0]               blocked_q;
   logic [3:0]               irq_stat_q;
   logic [3:0]               irq_mask_q;
   pau_pkg::pau_func_t       fn_q  [NCH];
   logic signed [DW-1:0]     asp_q [NCH];
   logic [TW-1:0]            t1_q  [NTM];
   logic [TW-1:0]            t2_q  [NTM];
   logic                     run_s1_q;
   logic                     run_s2_q;
   logic [DW-1:0]            rd_d;
   logic                     tick;
   logic [3:0]               cond_raw;
   logic [3:0]               timed;

   // Write decode of the register port.
   wire wr_ctrl  = wr_in && (addr_in == `PAU_A_CTRL);
   wire wr_istat = wr_in && (addr_in == `PAU_A_IRQ_STAT);
   wire wr_imask = wr_in && (addr_in == `PAU_A_IRQ_MASK);
   wire wr_block = wr_in && (addr_in == `PAU_A_BLOCK);
   wire wr_fn    = wr_in && (addr_in[5:2] == 4'(`PAU_A_FN_BASE >> 2));
   wire wr_asp   = wr_in && (addr_in[5:2] == 4'(`PAU_A_ASP_BASE >> 2));
   wire wr_tmr   = wr_in && (addr_in[5:2] == 4'(`PAU_A_TMR_BASE >> 2));
   wire [1:0] wch = addr_in[1:0];

   // Arming edge is the moment the initial blocking is judged.
   wire arm_edge = en_q && !en_prev_q;

   // Per-channel recognition, blocking and interrupt events.
   logic [3:0] block_now;
   logic [3:0] recog;
   logic [3:0] rise;
   logic [3:0] sensor_fn;
   always_comb begin
      for (int i = 0; i < NCH; i++) begin
         cond_raw[i]  = eval_cond(fn_q[i], pv_in, main_sp_in, asp_q[i],
                                  sensor_err_in, profile_event_in[i]);
         sensor_fn[i] = (fn_q[i] == pau_pkg::PAU_FN_SENSOR_BREAK);
         block_now[i] = arm_edge && blk_en_q[i] && cond_raw[i]
                     && !sensor_fn[i];
         recog[i]     = en_q && cond_raw[i]
                     && (sensor_fn[i]
                     || !(blocked_q[i] || block_now[i]));
         rise[i]      = recog[i] && !lamp_out[i];
      end
   end

   // Control register and its arming history.
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         en_q      <= 1'b0;
         en_prev_q <= 1'b0;
      end else begin
         en_prev_q <= en_q;
         if (wr_ctrl) begin
            en_q <= wr_data_in[`PAU_CTRL_EN_BIT];
         end
      end
   end

   // Blocking flags: set at arming, cleared once the condition drops.
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         blocked_q <= `PAU_RST_NIB;
      end else begin
         blocked_q <= (blocked_q & cond_raw & ~sensor_fn)
                    | block_now;
      end
   end

   // Interrupt status is sticky; a new event wins over a clear.
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         irq_stat_q <= `PAU_RST_NIB;
         irq_mask_q <= `PAU_RST_NIB;
         blk_en_q   <= `PAU_RST_NIB;
      end else begin
         irq_stat_q <= (irq_stat_q & ~(wr_istat ? wr_data_in[3:0]
                                                : 4'h0)) | rise;
         if (wr_imask) begin
            irq_mask_q <= wr_data_in[3:0];
         end
         if (wr_block) begin
            blk_en_q <= wr_data_in[3:0];
         end
      end
   end

   // Per-channel function and alarm setpoint settings.
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         for (int i = 0; i < NCH; i++) begin
            fn_q[i]  <= pau_pkg::PAU_FN_OFF;
            asp_q[i] <= `PAU_RST_WORD;
         end
      end else begin
         if (wr_fn) begin
            fn_q[wch] <= pau_pkg::pau_func_t'(wr_data_in[2:0]);
         end
         if (wr_asp) begin
            asp_q[wch] <= wr_data_in;
         end
      end
   end

   // Timer settings exist for the first two channels only.
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         for (int i = 0; i < NTM; i++) begin
            t1_q[i] <= '0;
            t2_q[i] <= '0;
         end
      end else if (wr_tmr && !wch[0]) begin
         t1_q[wch[1]] <= clamp_time(wr_data_in);
      end else if (wr_tmr && wch[0]) begin
         t2_q[wch[1]] <= clamp_time(wr_data_in);
      end
   end

   // Run input is a pin: two flip-flops before any use.
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         run_s1_q <= 1'b0;
         run_s2_q <= 1'b0;
      end else begin
         run_s1_q <= run_in;
         run_s2_q <= run_s1_q;
      end
   end

   pau_tick #(
      .TICK_CYCLES (TICK_CYCLES)
   ) u_tick (
      .clk_sys_in (clk_sys_in),
      .rst_n_in   (rst_n_in),
      .tick_out   (tick)
   );

   // Timed shaping on channels one and two; others follow directly.
   for (genvar g = 0; g < NTM; g++) begin : g_tmr
      pau_timer #(
         .TW (TW)
      ) u_timer (
         .clk_sys_in (clk_sys_in),
         .rst_n_in   (rst_n_in),
         .tick_in    (tick),
         .cond_in    (recog[g]),
         .t1_in      (t1_q[g]),
         .t2_in      (t2_q[g]),
         .out_out    (timed[g])
      );
   end
   assign timed[3:2] = recog[3:2];

   // Read selection.
   always_comb begin
      rd_d = '0;
      if (addr_in == `PAU_A_CTRL) begin
         rd_d[`PAU_CTRL_EN_BIT] = en_q;
      end else if (addr_in == `PAU_A_STATUS) begin
         rd_d[12:0] = {run_s2_q, blocked_q, alarm_out, lamp_out};
      end else if (addr_in == `PAU_A_IRQ_STAT) begin
         rd_d[3:0] = irq_stat_q;
      end else if (addr_in == `PAU_A_IRQ_MASK) begin
         rd_d[3:0] = irq_mask_q;
      end else if (addr_in == `PAU_A_BLOCK) begin
         rd_d[3:0] = blk_en_q;
      end else if (addr_in[5:2] == 4'(`PAU_A_FN_BASE >> 2)) begin
         rd_d[2:0] = fn_q[wch];
      end else if (addr_in[5:2] == 4'(`PAU_A_ASP_BASE >> 2)) begin
         rd_d = asp_q[wch];
      end else if (addr_in[5:2] == 4'(`PAU_A_TMR_BASE >> 2)) begin
         rd_d[TW-1:0] = wch[0] ? t2_q[wch[1]] : t1_q[wch[1]];
      end
   end

   // Registered outputs: lamps, gated alarms, interrupt, read data.
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         lamp_out    <= `PAU_RST_NIB;
         alarm_out   <= `PAU_RST_NIB;
         irq_out     <= 1'b0;
         rd_data_out <= '0;
      end else begin
         lamp_out    <= recog;
         alarm_out   <= run_s2_q ? timed : 4'h0;
         irq_out     <= |(irq_stat_q & irq_mask_q);
         rd_data_out <= rd_in ? rd_d : '0;
      end
   end

   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (!rst_n_in);

   sequence s_stopped;
      !run_s2_q;
   endsequence
   sequence s_blk_drop;
      blocked_q[0] ##1 !cond_raw[0];
   endsequence

   a_disabled_quiet: assert property (
      fn_q[0] == pau_pkg::PAU_FN_OFF |=> !lamp_out[0] && !alarm_out[0])
      else $error("Disabled channel raised an alarm.");
   a_sensor_alarm: assert property (
      en_q && fn_q[2] == pau_pkg::PAU_FN_SENSOR_BREAK && sensor_err_in
      |=> lamp_out[2])
      else $error("Sensor fault did not light the lamp.");
   a_event_only: assert property (
      fn_q[3] == pau_pkg::PAU_FN_PROFILE_EVENT && !profile_event_in[3]
      |=> !lamp_out[3])
      else $error("Event alarm without a profile event.");
   a_min_abs: assert property (
      en_q && fn_q[0] == pau_pkg::PAU_FN_MIN_ABS && pv_in < asp_q[0]
      && !blocked_q[0] && !block_now[0] |=> lamp_out[0])
      else $error("Minimum alarm missed.");
   a_max_abs: assert property (
      fn_q[1] == pau_pkg::PAU_FN_MAX_ABS && pv_in <= asp_q[1]
      |=> !lamp_out[1])
      else $error("Maximum alarm raised at or below setpoint.");
   a_stop_holds: assert property (
      s_stopped ##1 s_stopped |-> alarm_out == 4'h0)
      else $error("Alarm output active while stopped.");
   a_sensor_noblock: assert property (
      fn_q[2] == pau_pkg::PAU_FN_SENSOR_BREAK |-> !block_now[2])
      else $error("Sensor fault alarm was blocked.");
   a_block_release: assert property (
      s_blk_drop |=> !blocked_q[0])
      else $error("Blocking not released after condition dropped.");
   a_lamp_gate: assert property (
      blocked_q[0] ##1 blocked_q[0] |-> !lamp_out[0])
      else $error("Lamp lit for a blocked alarm.");

   // Bus, interrupt and output timing checks.
   a_rd_quiet: assert property (
      !rd_in |=> rd_data_out == '0)
      else $error("Read data shown without a read strobe.");
   a_irq_set_wins: assert property (
      rise[1] |=> irq_stat_q[1])
      else $error("Alarm onset did not set its status bit.");
   a_irq_level: assert property (
      |(irq_stat_q & irq_mask_q) |=> irq_out)
      else $error("Interrupt missing for an unmasked status bit.");
   a_irq_quiet: assert property (
      !(|(irq_stat_q & irq_mask_q)) |=> !irq_out)
      else $error("Interrupt raised with no unmasked status bit.");
   a_lamp_follow: assert property (
      recog[1] |=> lamp_out[1])
      else $error("Lamp did not show a recognized alarm.");
   a_off_quiet: assert property (
      fn_q[1] == pau_pkg::PAU_FN_OFF |=> !lamp_out[1] && !alarm_out[1])
      else $error("Disabled second channel raised an alarm.");
   a_direct_pass: assert property (
      run_s2_q && recog[2] |=> alarm_out[2])
      else $error("Untimed alarm did not reach its output.");
   a_init_block: assert property (
      arm_edge && blk_en_q[0] && cond_raw[0] && !sensor_fn[0]
      |=> !lamp_out[0])
      else $error("Condition present at arming was recognized.");
endmodule

// ==== process_alarm_unit_bench.sv ====
// Self-checking bench of the four-channel process alarm unit.
`include "pau_regs.svh"
module process_alarm_unit_bench;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int TCK = 10;
   logic               clk_sys_in = 1'b0;
   logic               rst_n_in = 1'b0;
   logic [5:0]         addr_in = 6'h00;
   logic [15:0]        wr_data_in = 16'h0000;
   logic               wr_in = 1'b0;
   logic               rd_in = 1'b0;
   logic [15:0]        rd_data_out;
   logic signed [15:0] pv_in;
   logic signed [15:0] main_sp_in;
   logic               sensor_err_in;
   logic [3:0]         profile_event_in;
   logic               run_in;
   logic [3:0]         alarm_out;
   logic [3:0]         lamp_out;
   logic               irq_out;
   logic [15:0]        rd_v;
   logic [2:0]         t_fn [13] = '{3'h5, 3'h5, 3'h5, 3'h5, 3'h7, 3'h7,
                                     3'h6, 3'h6, 3'h3, 3'h3, 3'h4, 3'h4, 3'h0};
   logic [15:0]        t_asp [13] = '{16'h000A, 16'h000A, 16'hFFF6, 16'hFFF6,
                                      16'h000A, 16'h000A, 16'hFFF6, 16'hFFF6,
                                      16'h0064, 16'h0064, 16'h0064, 16'h0064,
                                      16'h0064};
   logic [15:0]        t_pv [13] = '{16'h03F3, 16'h03ED, 16'h03ED, 16'h03F3,
                                     16'h03F3, 16'h03F2, 16'h03DD, 16'h03DE,
                                     16'h0063, 16'h0064, 16'h0065, 16'h0064,
                                     16'hFFFB};
   logic               t_exp [13] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0,
                                      1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0,
                                      1'b0};
   logic [15:0]        tm [3] = '{16'h0002, 16'h0000, 16'h0002};
   logic [15:0]        tn [3] = '{16'h0000, 16'h0002, 16'h0002};
   logic               e_early [3] = '{1'b1, 1'b0, 1'b1};
   logic               e_late [3] = '{1'b0, 1'b1, 1'b0};
   int                 error_cnt = 0;
   int                 check_count = 0;
   int                 cyc = 0;

   // The system clock toggles every half period of 100 ns.
   always #50 clk_sys_in = ~clk_sys_in;

   pau_proc_model u_proc (
      .clk_sys_in        (clk_sys_in),
      .pv_out            (pv_in),
      .main_sp_out       (main_sp_in),
      .sensor_err_out    (sensor_err_in),
      .profile_event_out (profile_event_in),
      .run_out           (run_in)
   );

   pau_top #(.TICK_CYCLES(TCK)) u_dut (
      .clk_sys_in       (clk_sys_in),
      .rst_n_in         (rst_n_in),
      .addr_in          (addr_in),
      .wr_data_in       (wr_data_in),
      .wr_in            (wr_in),
      .rd_in            (rd_in),
      .rd_data_out      (rd_data_out),
      .pv_in            (pv_in),
      .main_sp_in       (main_sp_in),
      .sensor_err_in    (sensor_err_in),
      .profile_event_in (profile_event_in),
      .run_in           (run_in),
      .alarm_out        (alarm_out),
      .lamp_out         (lamp_out),
      .irq_out          (irq_out)
   );

   // Prints the counts and the verdict, then stops the run.
   task automatic end_of_test;
      $display("Checks %0d, mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // A hung run is cut short after a generous number of cycles.
   always @(posedge clk_sys_in) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         $display("BAD timeout expected end seen hang");
         end_of_test();
      end
   end

   // Compares one value and reports a mismatch at once.
   task automatic chk(input string n, input logic [15:0] e,
                      input logic [15:0] g);
      check_count++;
      if (g !== e) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask

   // Compares the lamp and alarm pins together.
   task automatic pins(input logic [3:0] le, input logic [3:0] ae);
      chk("lamp_out", {12'h000, le}, {12'h000, lamp_out});
      chk("alarm_out", {12'h000, ae}, {12'h000, alarm_out});
   endtask

   // Waits a number of edges and steps past the updates of the last one.
   task automatic wt(input int n);
      repeat (n) @(posedge clk_sys_in);
      #1;
   endtask

   // One write cycle of the register port.
   task automatic wr(input logic [5:0] a, input logic [15:0] d);
      @(posedge clk_sys_in);
      addr_in <= a;
      wr_data_in <= d;
      wr_in <= 1'b1;
      @(posedge clk_sys_in);
      wr_in <= 1'b0;
   endtask

   // One read cycle; the data are taken in the cycle after the strobe.
   task automatic chk_rd(input logic [5:0] a, input logic [15:0] e);
      @(posedge clk_sys_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge clk_sys_in);
      rd_in <= 1'b0;
      #1 rd_v = rd_data_out;
      chk($sformatf("register %h", a), e, rd_v);
   endtask

   // Steps the process through the model and lets the pins settle.
   task automatic env(input logic [15:0] pv, input logic err,
                      input logic [3:0] ev, input logic run);
      u_proc.drive(pv, err, ev, run);
      wt(5);
   endtask

   // Main sequence of scenarios.
   initial begin
      repeat (10) @(posedge clk_sys_in);
      rst_n_in <= 1'b1;
      wt(1);
      pins(4'h0, 4'h0);
      chk("irq_out", 16'h0000, {15'h0000, irq_out});
      chk_rd(`PAU_A_STATUS, 16'h1000);
      chk_rd(`PAU_A_IRQ_STAT, 16'h0000);
      wr(6'h3F, 16'hFFFF);
      chk_rd(6'h3F, 16'h0000);
      wr(`PAU_A_TMR_BASE, 16'h2000);
      chk_rd(`PAU_A_TMR_BASE, 16'h1964);
      wr(`PAU_A_TMR_BASE, 16'h0000);
      wr(`PAU_A_CTRL, 16'h0001);
      // Channel two walks every comparing function over its boundaries.
      for (int i = 0; i < 13; i++) begin
         wr(`PAU_A_FN_BASE + 6'h01, {13'h0000, t_fn[i]});
         wr(`PAU_A_ASP_BASE + 6'h01, t_asp[i]);
         env(t_pv[i], i == 12, {4{i == 12}}, 1'b1);
         pins({2'b00, t_exp[i], 1'b0}, {2'b00, t_exp[i], 1'b0});
      end
      chk_rd(`PAU_A_ASP_BASE + 6'h01, 16'h0064);
      wr(`PAU_A_FN_BASE + 6'h02, 16'h0001);
      wr(`PAU_A_FN_BASE + 6'h03, 16'h0002);
      env(16'h0000, 1'b1, 4'h7, 1'b1);
      pins(4'h4, 4'h4);
      env(16'h0000, 1'b0, 4'h8, 1'b1);
      pins(4'h8, 4'h8);
      chk_rd(`PAU_A_STATUS, 16'h1088);
      env(16'h0000, 1'b0, 4'h8, 1'b0);
      pins(4'h8, 4'h0);
      chk_rd(`PAU_A_IRQ_STAT, 16'h000E);
      chk("irq_out", 16'h0000, {15'h0000, irq_out});
      wr(`PAU_A_IRQ_MASK, 16'h0004);
      wt(2);
      chk("irq_out", 16'h0001, {15'h0000, irq_out});
      env(16'h0100, 1'b0, 4'h0, 1'b1);
      wr(`PAU_A_IRQ_STAT, 16'h000E);
      chk_rd(`PAU_A_IRQ_STAT, 16'h0000);
      chk("irq_out", 16'h0000, {15'h0000, irq_out});
      // Channel one runs pulse, delay and intermittent timing in turn.
      wr(`PAU_A_FN_BASE, 16'h0003);
      wr(`PAU_A_ASP_BASE, 16'h0064);
      for (int k = 0; k < 3; k++) begin
         wr(`PAU_A_TMR_BASE, tm[k]);
         wr(`PAU_A_TMR_BASE + 6'h01, tn[k]);
         env(16'h0000, 1'b0, 4'h0, 1'b1);
         pins(4'h1, {3'b000, e_early[k]});
         wt(22);
         pins(4'h1, {3'b000, e_late[k]});
         env(16'h0100, 1'b0, 4'h0, 1'b1);
         pins(4'h0, 4'h0);
      end
      // A condition already true at arming stays hidden until it recurs.
      wr(`PAU_A_CTRL, 16'h0000);
      wr(`PAU_A_TMR_BASE, 16'h0000);
      wr(`PAU_A_TMR_BASE + 6'h01, 16'h0000);
      wr(`PAU_A_FN_BASE + 6'h03, 16'h0000);
      wr(`PAU_A_BLOCK, 16'h0005);
      env(16'h0000, 1'b1, 4'h0, 1'b1);
      wr(`PAU_A_CTRL, 16'h0001);
      wt(5);
      pins(4'h4, 4'h4);
      chk_rd(`PAU_A_STATUS, 16'h1144);
      env(16'h0100, 1'b1, 4'h0, 1'b1);
      env(16'h0000, 1'b1, 4'h0, 1'b1);
      pins(4'h5, 4'h5);
      end_of_test();
   end
endmodule
